// ===== common/microword_pkg.sv
/*
 * Shared constants for the microword field decoder: microword layout,
 * field codes, memory-management modes, state codes and the APB map.
 * Assumes a 48-bit microword and a 512-word control store.
 */
package microword_pkg;

  // ********************************************************************
  // Control store geometry
  // ********************************************************************
  localparam int ADDR_W = 9;
  localparam int WORD_W = 48;
  localparam int DEPTH = 512;
  localparam logic [8:0] UPC_RESET = 9'h000;
  localparam logic [8:0] POWERUP_BIT = 9'h001;

  // ********************************************************************
  // Microword field positions (lsb) and widths
  // ********************************************************************
  localparam int F_MPC = 0;
  localparam int F_MISC = 9;
  localparam int F_XFER = 12;
  localparam int F_BUSCTL = 13;
  localparam int F_MAINT = 15;
  localparam int F_BAR = 16;
  localparam int F_LONG = 17;
  localparam int F_AUX = 18;
  localparam int F_ALU = 19;
  localparam int F_BCTL = 24;
  localparam int F_SS = 28;
  localparam int F_ALU_OUT_SELECT = 30;
  localparam int F_BUT = 32;
  localparam int F_SRCSEL = 36;
  localparam int F_DSTSEL = 38;
  localparam int F_ODD = 40;
  localparam int F_PREV = 41;
  localparam int F_KERN = 42;
  localparam int F_SERV = 43;
  localparam int F_SPA = 44;

  // ********************************************************************
  // Miscellaneous-control codes (three multiplexed lines)
  // ********************************************************************
  localparam logic [2:0] MISC_NONE = 3'h0;
  localparam logic [2:0] MISC_INSTR_LOAD = 3'h1;
  localparam logic [2:0] MISC_STATUS_LOAD = 3'h2;
  localparam logic [2:0] MISC_FLAGS_LOAD = 3'h3;
  localparam logic [2:0] MISC_BRANCH_DEST = 3'h4;
  localparam logic [2:0] MISC_STACK_CHECK = 3'h5;
  localparam logic [2:0] MISC_COUNT_LOAD = 3'h6;
  localparam logic [2:0] MISC_COUNT_CLK = 3'h7;

  // Scratchpad address sources, shared by both half-step selects
  localparam logic [1:0] SPA_ROM = 2'h0;
  localparam logic [1:0] SPA_SRC = 2'h1;
  localparam logic [1:0] SPA_DST = 2'h2;
  localparam logic [1:0] SPA_BAR = 2'h3;

  // Memory-management modes and status word mode fields
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_USER = 2'h3;
  localparam int SW_CUR = 14;
  localparam int SW_PREV = 12;
  localparam int IR_SRC = 6;
  localparam int IR_DST = 0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_FETCH = 2'b01,
    ST_FIRST = 2'b10,
    ST_SECOND = 2'b11
  } seq_state_t;

  // ********************************************************************
  // APB register map (byte addresses)
  // ********************************************************************
  localparam int PADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CS_ADDR = 12'h008;
  localparam logic [11:0] REG_CS_LO = 12'h00c;
  localparam logic [11:0] REG_CS_HI = 12'h010;
  localparam logic [11:0] REG_MW_LO = 12'h014;
  localparam logic [11:0] REG_MW_HI = 12'h018;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STEP = 1;

endpackage : microword_pkg

// ===== src/microword_field_decoder.sv
/*
 * Microword field decoder: control store, microprogram counter and the
 * decode of every microword field into datapath control lines, with an
 * APB slave for loading the store and steering the sequencer.
 * Assumes the datapath samples the load enables on the rising edge at
 * which o_step_end is high, and that branch and service bits from the
 * external decoders are valid while the microstep runs.
 */
// Our own choices: register access over APB and the register addresses.
//
// Operation
// - Every microword holds a nine-bit address of the next microstep.
// - Three misc lines decode into seven individual load and check enables.
// - Status word load takes effect only at the end of the microstep.
// - Flag load updates N, Z, V and C at the microstep's end.
// - Counter load acts at step end; counter clock enable gates counting.
// - One bit marks an external bus transfer in this microstep.
// - One bit enables maintenance relocation for this microstep.
// - One bit loads the physical bus address register this microstep.
// - One bit enables the auxiliary ALU control for operate steps.
// - Four bits give operand and aux loads plus overflow, bus error checks.
// - Shifter select: straight, sign extend, swap bytes, external data.
// - ALU output select: status word, ALU, vector, external data.
// - First-half scratchpad select: microword, source, dest, bus pointer.
// - Second-half scratchpad select uses the same four-way encoding.
// - Odd force selects source register with bit zero set.
// - Previous-mode bit uses the status word's previous mode.
// - Force bit makes memory references use kernel mode.
// - Service bit enables service decode to redirect next address.
// - Four-bit branch test picks which condition may modify next address.
// - Register number field addresses the scratchpad in the next microstep.
// - Store holds 512 words of 48 bits, nine-bit addressed.
// - Branch bits are ORed onto the latched next address.
// - Initialize clears the counter; start-up forces address one.
// - Modes: kernel 00, user 11; current mode in status bits 15:14.
`timescale 1ns/1ps

module microword_field_decoder (
  // Clock, reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,

  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [microword_pkg::PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,

  // Processor side
  input wire logic i_init,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_status_word,
  input wire logic [3:0] i_bus_addr_ptr,
  input wire logic [microword_pkg::ADDR_W-1:0] i_branch_bits,
  input wire logic [microword_pkg::ADDR_W-1:0] i_service_bits,

  // Control lines
  output logic [microword_pkg::ADDR_W-1:0] o_next_microaddress,
  output logic o_step_end,
  output logic o_scratch_second_half,
  output logic o_instruction_latch_load,
  output logic o_status_word_load,
  output logic o_flags_load,
  output logic o_branch_to_dest_operand,
  output logic o_stack_limit_check_en,
  output logic o_count_load,
  output logic o_count_clk,
  output logic o_bus_transfer_flag,
  output logic [1:0] o_bus_cycle_type,
  output logic o_mmu_maint_relocate,
  output logic o_bus_addr_load,
  output logic o_long_cycle,
  output logic o_aux_alu_en,
  output logic [4:0] o_alu_ctl,
  output logic o_operand_load,
  output logic o_aux_operand_load,
  output logic o_overflow_check,
  output logic o_double_bus_error_check,
  output logic [1:0] o_shifter_select,
  output logic [1:0] o_alu_out_select,
  output logic [3:0] o_branch_test,
  output logic [3:0] o_scratch_addr,
  output logic [1:0] o_mmu_mode,
  output logic o_service_en
);
  import microword_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    // Sequencer
    seq_state_t state;
    logic [ADDR_W-1:0] upc;
    logic powerup;

    // Held microword
    logic [WORD_W-1:0] mw;
    logic [3:0] spa_num;
    logic [6:0] misc;
    logic [1:0] mode;
    logic [3:0] scratch;
    logic second;
    logic step_end;

    // Software side
    logic run;
    logic step_req;
    logic [ADDR_W-1:0] cs_addr;
    logic [31:0] cs_lo;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_t;

  core_t s_r;
  core_t s_nxt;
  logic [WORD_W-1:0] cstore [DEPTH];
  logic [WORD_W-1:0] rom_word;
  logic cs_we;
  logic apb_wr;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Scratchpad address multiplexer, shared by both half-steps
  function automatic logic [3:0] spa_pick(input logic [1:0] sel,
                                          input logic odd,
                                          input logic [3:0] num,
                                          input logic [15:0] ir,
                                          input logic [3:0] bar);
    logic [3:0] a;
    a = num;
    unique case (sel)
      SPA_ROM: a = num;
      SPA_SRC: a = {1'b0, ir[IR_SRC +: 3]};
      SPA_DST: a = {1'b0, ir[IR_DST +: 3]};
      SPA_BAR: a = bar;
    endcase
    // Odd force wins in both halves
    if (odd) begin
      a = {1'b0, ir[IR_SRC +: 3]} | 4'h1;
    end
    return a;
  endfunction : spa_pick

  // One-hot decode of the three multiplexed lines; bit n is code n+1
  function automatic logic [6:0] misc_decode(input logic [2:0] code);
    logic [7:0] hot;
    // Code zero drops out: no enable
    hot = 8'h01 << code;
    return hot[7:1];
  endfunction : misc_decode

  // ********************************************************************
  // Control store
  // ********************************************************************
  // No reset on the array: contents come only from software writes
  always_ff @(posedge i_ref_clk) begin
    if (cs_we) begin
      // Low half was staged in cs_lo
      cstore[s_r.cs_addr] <= {i_pwdata[WORD_W-33:0], s_r.cs_lo};
    end
  end

  // Async read: word ready in fetch
  assign rom_word = cstore[s_r.upc];
  // Writes only at the access edge
  assign apb_wr = i_psel & i_penable & i_pwrite & s_r.pready;
  assign cs_we = apb_wr & (i_paddr == REG_CS_HI);

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    logic [ADDR_W-1:0] nxt_addr;
    logic [WORD_W-1:0] w;
    nxt_addr = s_r.mw[F_MPC +: ADDR_W];
    w = rom_word;
    // Hold all; step end pulses
    s_nxt = s_r;
    s_nxt.step_end = 1'b0;

    // Branch and service bits only ever add ones to the latched address
    if (s_r.mw[F_BUT +: 4] != 4'h0) begin
      nxt_addr = nxt_addr | i_branch_bits;
    end
    if (s_r.mw[F_SERV]) begin
      nxt_addr = nxt_addr | i_service_bits;
    end

    // Sequencer: fetch, first half, second half per microstep
    unique case (s_r.state)
      ST_HALT: begin
        if (s_r.run | s_r.step_req) begin
          // Bit zero added once at power-up
          s_nxt.upc = s_r.powerup ? (s_r.upc | POWERUP_BIT)
                                  : s_r.upc;
          s_nxt.powerup = 1'b0;
          s_nxt.step_req = 1'b0;
          s_nxt.state = ST_FETCH;
        end
      end

      ST_FETCH: begin
        // Whole word captured at once, so fields never skew
        s_nxt.mw = w;
        s_nxt.misc = misc_decode(w[F_MISC +: 3]);
        if (w[F_KERN]) begin
          s_nxt.mode = MODE_KERNEL;
        end else if (w[F_PREV]) begin
          s_nxt.mode = i_status_word[SW_PREV +: 2];
        end else begin
          s_nxt.mode = i_status_word[SW_CUR +: 2];
        end
        s_nxt.scratch = spa_pick(w[F_SRCSEL +: 2], w[F_ODD], s_r.spa_num,
                                 i_instr, i_bus_addr_ptr);
        s_nxt.second = 1'b0;
        s_nxt.state = ST_FIRST;
      end

      ST_FIRST: begin
        s_nxt.scratch = spa_pick(s_r.mw[F_DSTSEL +: 2], s_r.mw[F_ODD],
                                 s_r.spa_num, i_instr,
                                 i_bus_addr_ptr);
        s_nxt.second = 1'b1;
        s_nxt.step_end = 1'b1;
        s_nxt.state = ST_SECOND;
      end

      ST_SECOND: begin
        // End of microstep: next address and register number latched
        s_nxt.upc = nxt_addr;
        s_nxt.spa_num = s_r.mw[F_SPA +: 4];
        // Halts here unless run is set
        s_nxt.state = s_r.run ? ST_FETCH : ST_HALT;
      end
    endcase

    // Initialize restarts the sequence at the power-up address
    // Run bit kept: restart at once
    if (i_init) begin
      s_nxt.upc = UPC_RESET;
      s_nxt.powerup = 1'b1;
      s_nxt.state = ST_HALT;
      s_nxt.step_end = 1'b0;
    end

    // APB setup cycle: answer ready in the access phase, zero wait
    s_nxt.pready = i_psel & ~i_penable;
    // Error stands only with pready
    s_nxt.pslverr = 1'b0;
    if (i_psel & ~i_penable) begin
      s_nxt.prdata = 32'h0000_0000;
      if (!i_pwrite) begin
        unique case (i_paddr)
          REG_CTRL: s_nxt.prdata = {30'h0000_0000, 1'b0, s_r.run};
          REG_STATUS: s_nxt.prdata = {20'h0_0000, s_r.state, s_r.powerup,
                                      s_r.upc};
          REG_CS_ADDR: s_nxt.prdata = {23'h00_0000, s_r.cs_addr};
          REG_CS_LO: s_nxt.prdata = s_r.cs_lo;
          REG_MW_LO: s_nxt.prdata = s_r.mw[31:0];
          REG_MW_HI: s_nxt.prdata = {16'h0000, s_r.mw[WORD_W-1:32]};
          default: s_nxt.pslverr = (i_paddr != REG_CS_HI);
        endcase
      end else begin
        // Read-only registers refuse writes
        unique case (i_paddr)
          REG_CTRL, REG_CS_ADDR, REG_CS_LO, REG_CS_HI: begin
            s_nxt.pslverr = 1'b0;
          end
          default: s_nxt.pslverr = 1'b1;
        endcase
      end
    end

    // APB writes take effect at the access edge
    if (apb_wr) begin
      unique case (i_paddr)
        REG_CTRL: begin
          s_nxt.run = i_pwdata[CTRL_RUN];
          // Step bit is consumed in halt
          s_nxt.step_req = i_pwdata[CTRL_STEP];
        end
        REG_CS_ADDR: s_nxt.cs_addr = i_pwdata[ADDR_W-1:0];
        REG_CS_LO: s_nxt.cs_lo = i_pwdata;
        // Auto-increment lets software stream the store in one pass
        REG_CS_HI: s_nxt.cs_addr = s_r.cs_addr + 9'h001;
        default: s_nxt.cs_addr = s_r.cs_addr;
      endcase
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '{state: ST_HALT,
               upc: UPC_RESET,
               powerup: 1'b1,
               mw: 48'h0000_0000_0000,
               spa_num: 4'h0,
               misc: 7'h00,
               mode: MODE_KERNEL,
               scratch: 4'h0,
               second: 1'b0,
               step_end: 1'b0,
               run: 1'b0,
               step_req: 1'b0,
               cs_addr: 9'h000,
               cs_lo: 32'h0000_0000,
               prdata: 32'h0000_0000,
               pready: 1'b0,
               pslverr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************************
  // Outputs, all taken from state flip-flops
  // ********************************************************************
  // Bus and register interface
  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;

  // Sequencer position
  assign o_next_microaddress = s_r.upc;
  assign o_step_end = s_r.step_end;
  assign o_scratch_second_half = s_r.second;

  // Decoded miscellaneous enables
  assign o_instruction_latch_load = s_r.misc[MISC_INSTR_LOAD - 1];
  assign o_status_word_load = s_r.misc[MISC_STATUS_LOAD - 1];
  assign o_flags_load = s_r.misc[MISC_FLAGS_LOAD - 1];
  assign o_branch_to_dest_operand = s_r.misc[MISC_BRANCH_DEST - 1];
  assign o_stack_limit_check_en = s_r.misc[MISC_STACK_CHECK - 1];
  assign o_count_load = s_r.misc[MISC_COUNT_LOAD - 1];
  assign o_count_clk = s_r.misc[MISC_COUNT_CLK - 1];

  // Bus control fields; cycle type is meaningful only with transfer flag
  assign o_bus_transfer_flag = s_r.mw[F_XFER];
  assign o_bus_cycle_type = s_r.mw[F_BUSCTL +: 2];
  assign o_mmu_maint_relocate = s_r.mw[F_MAINT];
  assign o_bus_addr_load = s_r.mw[F_BAR];
  assign o_long_cycle = s_r.mw[F_LONG];

  // ALU and operand control
  assign o_aux_alu_en = s_r.mw[F_AUX];
  assign o_alu_ctl = s_r.mw[F_ALU +: 5];

  // Operand field, one independent enable per bit
  assign o_operand_load = s_r.mw[F_BCTL];
  assign o_aux_operand_load = s_r.mw[F_BCTL + 1];
  assign o_overflow_check = s_r.mw[F_BCTL + 2];
  assign o_double_bus_error_check = s_r.mw[F_BCTL + 3];
  assign o_shifter_select = s_r.mw[F_SS +: 2];
  assign o_alu_out_select = s_r.mw[F_ALU_OUT_SELECT +: 2];

  // Sequencing, scratchpad and memory management
  assign o_branch_test = s_r.mw[F_BUT +: 4];

  // Set at fetch and half-step
  assign o_scratch_addr = s_r.scratch;
  assign o_mmu_mode = s_r.mode;
  assign o_service_en = s_r.mw[F_SERV];

endmodule : microword_field_decoder

// ===== bench/microword_field_decoder_properties.sv
/* Port checker for the microword field decoder.
   Assumes it is bound onto the decoder top module by the bind below. */
`timescale 1ns/1ps

module mfd_properties
  import microword_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_init,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_step_end,
  input wire logic o_scratch_second_half,
  input wire logic o_status_word_load,
  input wire logic [1:0] o_bus_cycle_type,
  input wire logic [1:0] o_shifter_select,
  input wire logic [microword_pkg::ADDR_W-1:0] o_next_microaddress
);
  // ****************************************
  // Properties, one clock domain
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_ready;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_ready_one;
    o_pready |=> !o_pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");
  property p_err;
    o_pslverr |-> o_pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_step_gap;
    o_step_end |=> !o_step_end [*2];
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("microstep shorter than three cycles");
  property p_second;
    $rose(o_scratch_second_half) |-> o_step_end;
  endproperty
  a_second: assert property (p_second)
    else $error("second half outside last cycle");
  // Fields launched at fetch must not move inside the step
  property p_fields;
    o_step_end |-> $stable(o_bus_cycle_type) && $stable(o_shifter_select)
      && $stable(o_status_word_load);
  endproperty
  a_fields: assert property (p_fields)
    else $error("field changed inside microstep");
  property p_upc;
    o_step_end |-> $stable(o_next_microaddress);
  endproperty
  a_upc: assert property (p_upc)
    else $error("microaddress moved before step end");
  property p_init;
    i_init |=> o_next_microaddress == 9'h000;
  endproperty
  a_init: assert property (p_init)
    else $error("initialize did not clear microaddress");

  c_step: cover property (o_step_end);
  c_err: cover property (o_pslverr);
  c_init: cover property (i_init);
  c_sw: cover property (o_step_end && o_status_word_load);
endmodule : mfd_properties

bind microword_field_decoder mfd_properties chk (.i_ref_clk, .i_resetn,
  .i_psel, .i_penable, .i_init, .o_pready, .o_pslverr, .o_step_end,
  .o_scratch_second_half, .o_status_word_load, .o_bus_cycle_type,
  .o_shifter_select, .o_next_microaddress);

// ===== bench/datapath_model.sv
/* Datapath stand-in: status word and loop counter fed by the decoder.
   Assumes the decoder's load enables are levels valid at step end. */
`timescale 1ns/1ps

module datapath_model (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_step_end,
  input wire logic i_status_word_load,
  input wire logic i_flags_load,
  input wire logic i_count_load,
  input wire logic i_count_clk,
  input wire logic [15:0] i_new_status,
  output logic [15:0] o_status_word,
  output logic [7:0] o_count
);
  // Loads land only at the edge that closes a microstep, never earlier
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status_word <= 16'h3000; // Current kernel, previous user
      o_count <= 8'h00;
    end else if (i_step_end) begin
      if (i_status_word_load) o_status_word <= i_new_status;
      if (i_flags_load) o_status_word[3:0] <= i_new_status[3:0];
      if (i_count_load) o_count <= i_new_status[7:0];
      if (i_count_clk) o_count <= o_count + 8'h01;
    end
  end
endmodule : datapath_model

// ===== bench/tb_microword_field_decoder.sv
/* Self-checking bench: loads microwords over APB, single-steps them.
   Assumes the decoder, the datapath model and the checker bind. */
`timescale 1ns/1ps

module tb_microword_field_decoder;
  import microword_pkg::*;
  typedef struct packed {
    logic [3:0] spa;
    logic serv, kern, prv, odd;
    logic [1:0] s2, s1;
    logic [3:0] bt;
    logic [1:0] am, ss;
    logic [3:0] opf;
    logic [4:0] alu;
    logic aux, lng, bar, maint;
    logic [1:0] bus;
    logic xfer;
    logic [2:0] misc;
    logic [8:0] next_microaddress;
  } mw_t;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, init = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, step_end, half2, xfer, maint, barl, lng, aux, srv;
  logic [15:0] instr = 16'h0000, sw, new_sw = 16'hc005;
  logic [3:0] bptr = 4'h9, opv, bt, saddr, prev_spa;
  logic [8:0] brb = 9'h100, svb = 9'h080, upc, cur;
  logic [6:0] en;
  logic [4:0] alu;
  logic [1:0] bus, ss, am, mode;
  int num_errors = 0, cmp_count = 0, cycles = 0;

  microword_field_decoder dut (.i_ref_clk(clk), .i_resetn(resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_init(init), .i_instr(instr), .i_status_word(sw),
    .i_bus_addr_ptr(bptr), .i_branch_bits(brb), .i_service_bits(svb),
    .o_next_microaddress(upc), .o_step_end(step_end),
    .o_scratch_second_half(half2), .o_instruction_latch_load(en[0]),
    .o_status_word_load(en[1]), .o_flags_load(en[2]),
    .o_branch_to_dest_operand(en[3]), .o_stack_limit_check_en(en[4]),
    .o_count_load(en[5]), .o_count_clk(en[6]), .o_bus_transfer_flag(xfer),
    .o_bus_cycle_type(bus), .o_mmu_maint_relocate(maint),
    .o_bus_addr_load(barl), .o_long_cycle(lng), .o_aux_alu_en(aux),
    .o_alu_ctl(alu), .o_operand_load(opv[0]), .o_aux_operand_load(opv[1]),
    .o_overflow_check(opv[2]), .o_double_bus_error_check(opv[3]),
    .o_shifter_select(ss), .o_alu_out_select(am), .o_branch_test(bt),
    .o_scratch_addr(saddr), .o_mmu_mode(mode), .o_service_en(srv));
  datapath_model dp (.i_ref_clk(clk), .i_resetn(resetn),
    .i_step_end(step_end), .i_status_word_load(en[1]), .i_flags_load(en[2]),
    .i_count_load(en[5]), .i_count_clk(en[6]), .i_new_status(new_sw),
    .o_status_word(sw), .o_count());

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  always #5 clk = ~clk;
  // A hung handshake would otherwise run forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Entered just after an edge; request held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  function automatic logic [3:0] sel(input logic [1:0] s, input logic o);
    if (o) return {1'b0, instr[8:7], 1'b1};
    case (s)
      SPA_ROM: return prev_spa;
      SPA_SRC: return {1'b0, instr[8:6]};
      SPA_DST: return {1'b0, instr[2:0]};
      default: return bptr;
    endcase
  endfunction : sel

  // Store one word at the current address, single-step it, judge outputs
  task automatic exec(input mw_t w);
    logic [31:0] rd;
    logic e;
    logic [3:0] first;
    logic [15:0] sw0, swx;
    logic [8:0] nxt;
    int n;
    w.next_microaddress = cur + 9'h001;
    apb(1'b1, REG_CS_ADDR, {23'h0, cur}, rd, e);
    apb(1'b1, REG_CS_LO, w[31:0], rd, e);
    apb(1'b1, REG_CS_HI, {16'h0, w[47:32]}, rd, e);
    sw0 = sw;
    apb(1'b1, REG_CTRL, 32'h2, rd, e);
    n = 0;
    do begin
      first = saddr;
      @(posedge clk);
      n++;
    end while (step_end !== 1'b1 && n < 20);
    chk("enables", w.misc == MISC_NONE ? 32'h0 : 32'h1 << (w.misc - 3'h1),
        {25'h0, en});
    chk("bus", {w.xfer, w.bus, w.maint, w.bar, w.lng, w.aux, w.alu},
        {xfer, bus, maint, barl, lng, aux, alu});
    chk("mux", {w.opf, w.ss, w.am, w.bt, w.serv},
        {opv, ss, am, bt, srv});
    chk("first", sel(w.s1, w.odd), first);
    chk("second", sel(w.s2, w.odd), saddr);
    chk("half", 32'h1, {31'h0, half2});
    chk("mode", w.kern ? MODE_KERNEL : (w.prv ? sw0[13:12] : sw0[15:14]),
        mode);
    chk("early status", sw0, sw);
    nxt = w.next_microaddress | (w.bt != 4'h0 ? brb : 9'h0) | (w.serv ? svb : 9'h0);
    swx = w.misc == MISC_STATUS_LOAD ? new_sw : sw0;
    if (w.misc == MISC_FLAGS_LOAD) swx = {sw0[15:4], new_sw[3:0]};
    @(posedge clk);
    chk("status", swx, sw);
    chk("next", nxt, upc);
    prev_spa = w.spa;
    cur = nxt;
  endtask : exec

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] rd;
    logic e;
    chk("reset upc", 9'h000, upc);
    apb(1'b0, REG_STATUS, 32'h0, rd, e);
    chk("status reg", 32'h200, rd);
    apb(1'b0, 12'h01c, 32'h0, rd, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  // Every misc code, each select code and bus type in one sweep
  task automatic t_misc;
    mw_t w;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      w = '0;
      w.misc = m;
      w.bus = m[1:0];
      w.ss = m[1:0];
      w.am = ~m[1:0];
      w.s1 = m[1:0];
      w.s2 = m[2:1];
      w.opf = 4'h1 << m[1:0];
      w.spa = 4'h8 + {1'b0, m};
      w.xfer = m[0];
      w.maint = m[1];
      w.bar = m[2];
      w.aux = m[0];
      w.lng = m[1];
      w.alu = {2'b0, m} ^ 5'h15;
      if (i == 3) new_sw <= 16'h000a;
      exec(w);
    end
    $display("test misc done");
  endtask : t_misc

  task automatic t_branch;
    mw_t w;
    w = '0;
    w.s1 = SPA_SRC;
    w.s2 = SPA_BAR;
    w.bt = 4'h3;
    exec(w);
    w.bt = 4'h0;
    w.serv = 1'b1;
    exec(w);
    w.bt = 4'hf;
    exec(w);
    $display("test branch done");
  endtask : t_branch

  // Previous mode set apart from current so each override shows
  task automatic t_modes;
    mw_t w;
    instr <= 16'h0103;
    new_sw <= 16'h3000;
    for (int k = 0; k < 4; k++) begin
      w = '0;
      w.misc = (k == 0) ? MISC_STATUS_LOAD : MISC_NONE;
      w.odd = (k == 1);
      w.prv = (k > 1);
      w.kern = (k == 3);
      w.s1 = SPA_SRC;
      w.s2 = SPA_ROM;
      w.spa = 4'h6;
      exec(w);
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_init;
    mw_t w;
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    @(posedge clk);
    chk("init upc", 9'h000, upc);
    cur = 9'h001;
    w = '0;
    w.s1 = SPA_DST;
    w.s2 = SPA_DST;
    exec(w);
    $display("test init done");
  endtask : t_init

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    cur = 9'h001;
    prev_spa = 4'h0;
    t_reset();
    t_misc();
    t_branch();
    t_modes();
    t_init();
    print_verdict();
  end
endmodule : tb_microword_field_decoder
